// *** cam_pkg.sv ***
// Constants for the acceptance mask register bank
package cam_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MASK0_STD_ID_HIGH = 8'h20;
  localparam logic [7:0] ADDR_MASK0_STD_ID_LOW = 8'h21;
  localparam logic [7:0] ADDR_MASK0_EXT_ID_HIGH = 8'h22;
  localparam logic [7:0] ADDR_MASK0_EXT_ID_LOW = 8'h23;
  localparam logic [7:0] ADDR_MASK1_STD_ID_HIGH = 8'h24;
  localparam logic [7:0] ADDR_MASK1_STD_ID_LOW = 8'h25;
  localparam logic [7:0] ADDR_MASK1_EXT_ID_HIGH = 8'h26;
  localparam logic [7:0] ADDR_MASK1_EXT_ID_LOW = 8'h27;
  localparam int MASK_COUNT = 2;
  localparam int REGS_PER_MASK = 4;
  // Byte index inside one mask block
  localparam logic [1:0] IDX_STD_HIGH = 2'h0;
  localparam logic [1:0] IDX_STD_LOW = 2'h1;
  localparam logic [1:0] IDX_EXT_HIGH = 2'h2;
  localparam logic [1:0] IDX_EXT_LOW = 2'h3;
  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] STD_LOW_IMPL_BITS = 8'he3;
  localparam logic [7:0] FULL_BYTE_BITS = 8'hff;
  localparam int STD_LOW_SID_LSB = 5;
  localparam int STD_LOW_EID_MSB = 1;
  localparam int ID_WIDTH = 29;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [1:0] RX_MODE_DATA_FILTER = 2'h0;
endpackage : cam_pkg

// *** cam_cmp_if.sv ***
// Interface between the mask bank and one acceptance comparator
`timescale 1ns/1ps
`default_nettype none
interface cam_cmp_if;
  logic [28:0] mask_bits;
  logic [28:0] filter_bits;
  logic filter_ext_sel;
  logic [1:0] rx_mode_field;
  logic [10:0] rx_std_id;
  logic [17:0] rx_ext_id;
  logic rx_is_ext;
  logic [7:0] rx_data0;
  logic [7:0] rx_data1;
  logic match;
  modport bank (output mask_bits, filter_bits, filter_ext_sel, rx_mode_field, rx_std_id, rx_ext_id,
                output rx_is_ext, rx_data0, rx_data1, input match);
  modport cmp (input mask_bits, filter_bits, filter_ext_sel, rx_mode_field, rx_std_id, rx_ext_id,
               input rx_is_ext, rx_data0, rx_data1, output match);
endinterface : cam_cmp_if
`default_nettype wire

// *** cam_accept_cmp.sv ***
// Acceptance comparator for one mask and its filter
`timescale 1ns/1ps
`default_nettype none
module cam_accept_cmp (
  cam_cmp_if.cmp bus
);
  logic [28:0] rx_bits;
  logic [28:0] cmp_en;
  logic type_ok;
  logic data_filter;

  // ----------------------------------------------------------------
  // Received bits lined up with the mask layout
  // ----------------------------------------------------------------
  always_comb begin
    data_filter = (bus.rx_mode_field == cam_pkg::RX_MODE_DATA_FILTER) && !bus.filter_ext_sel;
    type_ok = (bus.rx_is_ext == bus.filter_ext_sel);
    if (bus.rx_is_ext) begin
      rx_bits = {bus.rx_std_id, bus.rx_ext_id};
      cmp_en = {29{1'b1}};
    end else if (data_filter) begin
      // Extended bytes of the mask act on the first two data bytes
      rx_bits = {bus.rx_std_id, 2'h0, bus.rx_data0, bus.rx_data1};
      cmp_en = {{11{1'b1}}, 2'h0, {16{1'b1}}};
    end else begin
      rx_bits = {bus.rx_std_id, 18'h00000};
      cmp_en = {{11{1'b1}}, 18'h00000};
    end
  end

  // Mask bit zero makes the bit a don't-care
  assign bus.match = type_ok && ~|((rx_bits ^ bus.filter_bits) & bus.mask_bits & cmp_en);
endmodule : cam_accept_cmp
`default_nettype wire

// *** can_acceptance_mask_regs.sv ***
// Acceptance mask register bank with its two comparators
`timescale 1ns/1ps
`default_nettype none
module can_acceptance_mask_regs (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_config_mode,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic [1:0][28:0] i_filter_bits,
  input wire logic [1:0] i_extended_frame_select,
  input wire logic [1:0][1:0] i_receive_operating_mode_field,
  input wire logic i_rx_valid,
  input wire logic [10:0] i_rx_std_id,
  input wire logic [17:0] i_rx_ext_id,
  input wire logic i_rx_is_ext,
  input wire logic [7:0] i_rx_data0,
  input wire logic [7:0] i_rx_data1,
  output logic [1:0] o_accept,
  output logic o_accept_valid
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Unpacked per byte so every byte has one writer
  logic [7:0] mask_reg [cam_pkg::MASK_COUNT][cam_pkg::REGS_PER_MASK];
  logic addr_hit;
  logic mask_sel;
  logic [1:0] byte_sel;
  logic [7:0] impl_bits;
  logic [7:0] rdata_next;
  logic [1:0] match;
  logic wr_allowed;
  logic rd_visible;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Only the eight mapped bytes hit; any other address stores nothing
  always_comb begin
    addr_hit = 1'b0;
    mask_sel = 1'b0;
    byte_sel = cam_pkg::IDX_STD_HIGH;
    case (i_reg_addr)
      // First mask block
      cam_pkg::ADDR_MASK0_STD_ID_HIGH: begin
        addr_hit = 1'b1;
        byte_sel = cam_pkg::IDX_STD_HIGH;
      end
      cam_pkg::ADDR_MASK0_STD_ID_LOW: begin
        addr_hit = 1'b1;
        byte_sel = cam_pkg::IDX_STD_LOW;
      end
      cam_pkg::ADDR_MASK0_EXT_ID_HIGH: begin
        addr_hit = 1'b1;
        byte_sel = cam_pkg::IDX_EXT_HIGH;
      end
      cam_pkg::ADDR_MASK0_EXT_ID_LOW: begin
        addr_hit = 1'b1;
        byte_sel = cam_pkg::IDX_EXT_LOW;
      end
      // Second mask block
      cam_pkg::ADDR_MASK1_STD_ID_HIGH: begin
        addr_hit = 1'b1;
        mask_sel = 1'b1;
        byte_sel = cam_pkg::IDX_STD_HIGH;
      end
      cam_pkg::ADDR_MASK1_STD_ID_LOW: begin
        addr_hit = 1'b1;
        mask_sel = 1'b1;
        byte_sel = cam_pkg::IDX_STD_LOW;
      end
      cam_pkg::ADDR_MASK1_EXT_ID_HIGH: begin
        addr_hit = 1'b1;
        mask_sel = 1'b1;
        byte_sel = cam_pkg::IDX_EXT_HIGH;
      end
      cam_pkg::ADDR_MASK1_EXT_ID_LOW: begin
        addr_hit = 1'b1;
        mask_sel = 1'b1;
        byte_sel = cam_pkg::IDX_EXT_LOW;
      end
      default: begin
        addr_hit = 1'b0;
        mask_sel = 1'b0;
        byte_sel = cam_pkg::IDX_STD_HIGH;
      end
    endcase
  end

  // Bits 4 to 2 of the standard low byte hold no storage
  always_comb begin
    if (byte_sel == cam_pkg::IDX_STD_LOW) begin
      impl_bits = cam_pkg::STD_LOW_IMPL_BITS;
    end else begin
      impl_bits = cam_pkg::FULL_BYTE_BITS;
    end
  end

  // ----------------------------------------------------------------
  // Access qualifiers
  // ----------------------------------------------------------------
  // A write outside configuration mode is dropped without answer
  assign wr_allowed = i_reg_wr && addr_hit && i_config_mode;
  // Reads outside configuration mode show zero; the stored masks stay
  assign rd_visible = addr_hit && i_config_mode;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Each byte has its own enable, so only the addressed byte moves
  for (genvar m = 0; m < cam_pkg::MASK_COUNT; m++) begin : g_mask
    for (genvar r = 0; r < cam_pkg::REGS_PER_MASK; r++) begin : g_byte
      logic wr_en;
      assign wr_en = wr_allowed && (mask_sel == 1'(m)) && (byte_sel == 2'(r));
      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          mask_reg[m][r] <= cam_pkg::MASK_RESET;
        end else if (wr_en) begin
          mask_reg[m][r] <= i_reg_wdata & impl_bits;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb begin
    if (rd_visible) begin
      rdata_next = mask_reg[mask_sel][byte_sel] & impl_bits;
    end else begin
      rdata_next = 8'h00;
    end
  end

  // Read strobe answered one edge later
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Comparators, one per mask
  // ----------------------------------------------------------------
  // Mask n pairs with filter n and mode field n; the stored mask acts in every mode
  for (genvar g = 0; g < cam_pkg::MASK_COUNT; g++) begin : g_cmp
    cam_cmp_if cif ();
    logic [28:0] mask_vec;
    assign mask_vec = {mask_reg[g][cam_pkg::IDX_STD_HIGH],
                       mask_reg[g][cam_pkg::IDX_STD_LOW][7:cam_pkg::STD_LOW_SID_LSB],
                       mask_reg[g][cam_pkg::IDX_STD_LOW][cam_pkg::STD_LOW_EID_MSB:0],
                       mask_reg[g][cam_pkg::IDX_EXT_HIGH],
                       mask_reg[g][cam_pkg::IDX_EXT_LOW]};
    assign cif.mask_bits = mask_vec;
    assign cif.filter_bits = i_filter_bits[g];
    assign cif.filter_ext_sel = i_extended_frame_select[g];
    assign cif.rx_mode_field = i_receive_operating_mode_field[g];
    assign cif.rx_std_id = i_rx_std_id;
    assign cif.rx_ext_id = i_rx_ext_id;
    assign cif.rx_is_ext = i_rx_is_ext;
    assign cif.rx_data0 = i_rx_data0;
    assign cif.rx_data1 = i_rx_data1;
    assign match[g] = cif.match;
    cam_accept_cmp u_cmp (
      .bus(cif.cmp)
    );
  end

  // ----------------------------------------------------------------
  // Acceptance result
  // ----------------------------------------------------------------
  // Valid strobe one edge after the frame strobe
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_accept_valid <= 1'b0;
    end else begin
      o_accept_valid <= i_rx_valid;
    end
  end

  // Result holds until the next frame
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_accept <= 2'h0;
    end else if (i_rx_valid) begin
      o_accept <= match;
    end
  end
endmodule : can_acceptance_mask_regs
`default_nettype wire

// *** cam_properties.sv ***
// Checker for the acceptance mask register bank
`timescale 1ns/1ps
`default_nettype none
module cam_properties (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_config_mode,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic i_rx_valid,
  input wire logic [1:0] o_accept,
  input wire logic o_accept_valid
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_read;
    i_reg_rd ##1 o_reg_rvalid;
  endsequence
  sequence s_frame;
    i_rx_valid ##1 o_accept_valid;
  endsequence
  a_read_answer: assert property (i_reg_rd |-> s_read) else $error("no rvalid");
  a_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd)) else $error("stray rvalid");
  a_mode_zero: assert property (i_reg_rd && !i_config_mode |=> o_reg_rdata == 8'h00) else $error("not zero");
  a_unmapped_zero: assert property (i_reg_rd && i_reg_addr[7:3] != 5'h04 |=> o_reg_rdata == 8'h00)
    else $error("unmapped not zero");
  a_low_unimpl: assert property (i_reg_rd && {i_reg_addr[7:3], i_reg_addr[1:0]} == 7'h11
    |=> o_reg_rdata[4:2] == 3'h0) else $error("bits 4:2 set");
  a_accept_answer: assert property (i_rx_valid |-> s_frame) else $error("no accept");
  a_accept_cause: assert property (o_accept_valid |-> $past(i_rx_valid)) else $error("stray accept");
  a_accept_hold: assert property (!i_rx_valid |=> $stable(o_accept)) else $error("accept moved");
endmodule : cam_properties
`default_nettype wire

// *** tb.sv ***
// Testbench for the acceptance mask register bank
`timescale 1ns/1ps
`default_nettype none
bind can_acceptance_mask_regs cam_properties cam_properties_i (.*);
module tb;
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_config_mode = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic i_rx_valid = 1'b0, i_rx_is_ext = 1'b0, o_reg_rvalid, o_accept_valid;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata, i_rx_data0 = 8'h00, i_rx_data1 = 8'h00;
  logic [1:0][28:0] i_filter_bits = {2{11'h5a5, 18'h2c3d1}};
  logic [1:0][1:0] i_receive_operating_mode_field = 4'h0;
  logic [1:0] i_extended_frame_select = 2'h0, o_accept;
  logic [10:0] i_rx_std_id = 11'h000;
  logic [17:0] i_rx_ext_id = 18'h00000;
  int n_mismatch = 0, checks = 0;
  always #50 i_clk_sys = ~i_clk_sys;
  can_acceptance_mask_regs can_acceptance_mask_regs_i (.*);
  task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : cmp
  task automatic rg(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} <= {w, !w, a, d};
    @(posedge i_clk_sys);
    {i_reg_wr, i_reg_rd} <= 2'h0;
    #1 cmp("rvalid", {7'h00, !w}, {7'h00, o_reg_rvalid});
    if (!w) cmp("rdata", d, o_reg_rdata);
  endtask : rg
  task automatic fr(input logic [45:0] f, input logic [1:0] e);
    @(posedge i_clk_sys);
    {i_rx_std_id, i_rx_ext_id, i_rx_is_ext, i_rx_data0, i_rx_data1, i_rx_valid} <= {f, 1'b1};
    @(posedge i_clk_sys);
    i_rx_valid <= 1'b0;
    #1 cmp("accept", {6'h00, e}, {6'h00, o_accept});
    cmp("accept_valid", 8'h01, {7'h00, o_accept_valid});
  endtask : fr
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rg(1'b0, 8'h20 + 8'(i), 8'h00);
    for (int i = 0; i < 8; i++) begin
      rg(1'b1, 8'h20 + 8'(i), 8'h35 * 8'(i + 1));
      rg(1'b0, 8'h20 + 8'(i), 8'h35 * 8'(i + 1) & (i % 4 == 1 ? 8'he3 : 8'hff));
    end
    @(posedge i_clk_sys) i_config_mode <= 1'b0;
    rg(1'b1, 8'h20, 8'h00);
    rg(1'b0, 8'h20, 8'h00);
    @(posedge i_clk_sys) i_config_mode <= 1'b1;
    rg(1'b0, 8'h20, 8'h35);
    rg(1'b0, 8'h28, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 8; i++) rg(1'b1, 8'h20 + 8'(i), i < 5 ? 8'hff : 8'h00);
    fr({11'h5a5, 18'h0, 1'b0, 16'hc3d1}, 2'b11);
    fr({11'h5a5, 18'h0, 1'b0, 16'hc2d1}, 2'b10);
    fr({11'h5a5, 18'h0, 1'b0, 16'hc3d0}, 2'b10);
    fr({11'h1a5, 18'h0, 1'b0, 16'hc3d1}, 2'b00);
    fr({11'h5a5, 18'h2c3d1, 1'b1, 16'h0}, 2'b00);
    @(posedge i_clk_sys) i_extended_frame_select <= 2'h3;
    fr({11'h5a5, 18'h2c3d1, 1'b1, 16'h0}, 2'b11);
    fr({11'h5a5, 18'h3c3d1, 1'b1, 16'h0}, 2'b10);
    fr({11'h5a5, 18'h2c2d1, 1'b1, 16'h0}, 2'b10);
    fr({11'h5a5, 18'h2c3d0, 1'b1, 16'h0}, 2'b10);
    fr({11'h5a4, 18'h2c3d1, 1'b1, 16'h0}, 2'b10);
    @(posedge i_clk_sys) {i_extended_frame_select, i_receive_operating_mode_field} <= 6'h01;
    fr({11'h5a5, 18'h0, 1'b0, 16'h0}, 2'b11);
    $display("test acceptance done");
    conclude();
  end
endmodule : tb
`default_nettype wire
